// ==== core/scfg_top.sv ====
// Supply software reset, sense refresh and overtemperature warning config block
`timescale 1ns/1ps
`include "scfg_defs.svh"
module scfg_top #(
  parameter int unsigned RESTART_500_CYC = `SCFG_US_TO_CYC(`SCFG_RESTART_500_US),
  parameter int unsigned RESTART_1S_CYC = `SCFG_US_TO_CYC(`SCFG_RESTART_1S_US),
  parameter int unsigned RESTART_2S_CYC = `SCFG_US_TO_CYC(`SCFG_RESTART_2S_US),
  parameter int unsigned DEBOUNCE_CYC = `SCFG_US_TO_CYC(`SCFG_DEBOUNCE_US),
  parameter int unsigned CS_RATE0_CYC = `SCFG_US_TO_CYC(`SCFG_CS_RATE0_US),
  parameter int unsigned CS_RATE1_CYC = `SCFG_US_TO_CYC(`SCFG_CS_RATE1_US),
  parameter int unsigned CS_RATE2_CYC = `SCFG_US_TO_CYC(`SCFG_CS_RATE2_US),
  parameter int unsigned CS_RATE3_CYC = `SCFG_US_TO_CYC(`SCFG_CS_RATE3_US)
)(
  input wire logic clk,
  input wire logic rst,
  input wire scfg_pkg::scfg_addr_t addr,
  input wire scfg_pkg::scfg_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output scfg_pkg::scfg_byte_t rdata,
  input wire scfg_pkg::scfg_byte_t temp_zone_one,
  input wire scfg_pkg::scfg_byte_t temp_zone_two,
  input wire scfg_pkg::scfg_byte_t trip_level_one,
  input wire scfg_pkg::scfg_byte_t trip_level_two,
  input wire logic undervoltage_flag_a,
  input wire logic undervoltage_flag_b,
  input wire logic soft_start_filter_flag_a,
  input wire logic soft_start_filter_flag_b,
  input wire logic checksum_flag,
  input wire logic line_sense_flag,
  output logic supply_on_a,
  output logic supply_on_b,
  output logic overtemp_trip_zone_one,
  output logic overtemp_trip_zone_two,
  output logic overtemp_warning_one,
  output logic overtemp_warning_two,
  output logic power_ok_channel_a,
  output logic power_ok_channel_b,
  output logic current_sense_sample,
  output logic irq
);
  import scfg_pkg::*;

  logic [3:0] ctl_q, ctl_d;
  logic [1:0] cs_q, cs_d;
  scfg_byte_t otw_q, otw_d;
  logic [3:0] stat_q, stat_d;
  logic [3:0] mask_q, mask_d;
  logic [1:0] lsen_q, lsen_d;
  scfg_byte_t rdata_q, rdata_d;
  logic [1:0] start;
  logic [1:0] done;
  logic [1:0] on;
  logic [1:0] warn;
  logic [1:0] warn_rise;
  logic [1:0] trip;
  logic [1:0] pg;
  logic [1:0] raw;
  logic [1:0] nodeb;
  logic [1:0] trig;
  scfg_pair_t thr [2];
  scfg_byte_t temp [2];
  scfg_byte_t tlvl [2];
  logic [1:0] uv;
  logic [1:0] ss;
  logic [24:0] dly_cyc;
  logic [21:0] cs_cnt_q, cs_cnt_d;
  logic [21:0] cs_lim;
  logic cs_pulse_q, cs_pulse_d;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Per-channel wiring
  assign temp[0] = temp_zone_one;
  assign temp[1] = temp_zone_two;
  assign tlvl[0] = trip_level_one;
  assign tlvl[1] = trip_level_two;
  assign thr[0] = otw_q[`SCFG_OTW_THR1_LSB +: 2];
  assign thr[1] = otw_q[`SCFG_OTW_THR2_LSB +: 2];
  assign nodeb = {otw_q[`SCFG_OTW_NODEB2], otw_q[`SCFG_OTW_NODEB1]};
  assign trig = {otw_q[`SCFG_OTW_TRIG2], otw_q[`SCFG_OTW_TRIG1]};
  assign uv = {undervoltage_flag_b, undervoltage_flag_a};
  assign ss = {soft_start_filter_flag_b, soft_start_filter_flag_a};

  // Register file
  always_comb
  begin
    ctl_d = {ctl_q[3:2], ctl_q[1:0] & ~start};
    cs_d = cs_q;
    otw_d = otw_q;
    mask_d = mask_q;
    lsen_d = lsen_q;
    stat_d = stat_q;
    rdata_d = 8'h00;
    if (wr)
    begin
      case (addr)
        `SCFG_ADDR_RST_CTL: ctl_d = {wdata[3:2], ctl_d[1:0] | wdata[1:0]};
        `SCFG_ADDR_CS_RATE: cs_d = wdata[1:0];
        `SCFG_ADDR_OTW: otw_d = wdata;
        `SCFG_ADDR_IRQ_MASK: mask_d = wdata[3:0];
        `SCFG_ADDR_LS_EN: lsen_d = wdata[1:0];
        default: ctl_d = ctl_d;
      endcase
    end
    if (rd)
    begin
      case (addr)
        `SCFG_ADDR_RST_CTL: rdata_d = {4'h0, ctl_q};
        `SCFG_ADDR_CS_RATE: rdata_d = {6'h00, cs_q};
        `SCFG_ADDR_OTW: rdata_d = otw_q;
        `SCFG_ADDR_IRQ_STAT:
        begin
          rdata_d = {4'h0, stat_q};
          stat_d = 4'h0;
        end
        `SCFG_ADDR_IRQ_MASK: rdata_d = {4'h0, mask_q};
        `SCFG_ADDR_LS_EN: rdata_d = {6'h00, lsen_q};
        default: rdata_d = 8'h00;
      endcase
    end
    // Set wins over read clear
    stat_d[`SCFG_IRQ_DONE_LSB +: 2] = stat_d[`SCFG_IRQ_DONE_LSB +: 2] | done;
    stat_d[`SCFG_IRQ_WARN_LSB +: 2] = stat_d[`SCFG_IRQ_WARN_LSB +: 2] | warn_rise;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_q <= `SCFG_RST_CTL_RESET;
      cs_q <= `SCFG_CS_RATE_RESET;
      otw_q <= `SCFG_OTW_RESET;
      stat_q <= 4'h0;
      mask_q <= `SCFG_IRQ_MASK_RESET;
      lsen_q <= `SCFG_LS_EN_RESET;
      rdata_q <= 8'h00;
    end
    else
    begin
      ctl_q <= ctl_d;
      cs_q <= cs_d;
      otw_q <= otw_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      lsen_q <= lsen_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = |(stat_q & mask_q);

  // Restart delay select
  always_comb
  begin
    case (ctl_q[`SCFG_DLY_LSB +: 2])
      2'b00: dly_cyc = 25'h0;
      2'b01: dly_cyc = 25'(RESTART_500_CYC);
      2'b10: dly_cyc = 25'(RESTART_1S_CYC);
      2'b11: dly_cyc = 25'(RESTART_2S_CYC);
      default: dly_cyc = 25'h0;
    endcase
  end

  // Sense refresh timer
  always_comb
  begin
    case (cs_q)
      2'b00: cs_lim = 22'(CS_RATE0_CYC);
      2'b01: cs_lim = 22'(CS_RATE1_CYC);
      2'b10: cs_lim = 22'(CS_RATE2_CYC);
      2'b11: cs_lim = 22'(CS_RATE3_CYC);
      default: cs_lim = 22'(CS_RATE0_CYC);
    endcase
    cs_pulse_d = cs_cnt_q >= cs_lim - 22'h1;
    cs_cnt_d = cs_pulse_d ? 22'h0 : cs_cnt_q + 22'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs_cnt_q <= 22'h0;
      cs_pulse_q <= 1'b0;
    end
    else
    begin
      cs_cnt_q <= cs_cnt_d;
      cs_pulse_q <= cs_pulse_d;
    end
  end

  assign current_sense_sample = cs_pulse_q;

  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    scfg_seq_t st_q, st_d;
    logic [24:0] cnt_q, cnt_d;
    logic on_q;
    logic [19:0] dcnt_q, dcnt_d;
    logic w_q, w_d;
    logic t_q;
    logic pg_q, pg_d;

    // Off, wait, restart sequence
    always_comb
    begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
        SEQ_IDLE:
          if (ctl_q[i])
          begin
            st_d = SEQ_OFF;
            cnt_d = dly_cyc;
          end
        SEQ_OFF:
          if (cnt_q == 25'h0)
            st_d = SEQ_RESTART;
          else
            cnt_d = cnt_q - 25'h1;
        SEQ_RESTART: st_d = SEQ_IDLE;
        default: st_d = SEQ_IDLE;
      endcase
    end

    // Warning threshold, debounce and power-good
    always_comb
    begin
      raw[i] = {1'b0, temp[i]} > {1'b0, tlvl[i]} + {7'h00, thr[i]} + 9'h001;
      dcnt_d = 20'h0;
      w_d = w_q;
      if (nodeb[i])
        w_d = raw[i];
      else if (raw[i] != w_q)
      begin
        if (dcnt_q >= 20'(DEBOUNCE_CYC) - 20'h1)
          w_d = raw[i];
        else
          dcnt_d = dcnt_q + 20'h1;
      end
      pg_d = ~(uv[i] | ~on_q | checksum_flag | ss[i] | (lsen_q[i] & line_sense_flag)
             | (trig[i] & w_q));
    end

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        st_q <= SEQ_IDLE;
        cnt_q <= 25'h0;
        on_q <= 1'b1;
        dcnt_q <= 20'h0;
        w_q <= 1'b0;
        t_q <= 1'b0;
        pg_q <= 1'b0;
      end
      else
      begin
        st_q <= st_d;
        cnt_q <= cnt_d;
        on_q <= st_d != SEQ_OFF;
        dcnt_q <= dcnt_d;
        w_q <= w_d;
        t_q <= temp[i] > tlvl[i];
        pg_q <= pg_d;
      end
    end

    assign start[i] = (st_q == SEQ_IDLE) & ctl_q[i];
    assign done[i] = st_q == SEQ_RESTART;
    assign on[i] = on_q;
    assign warn[i] = w_q;
    assign warn_rise[i] = w_d & ~w_q;
    assign trip[i] = t_q;
    assign pg[i] = pg_q;

    AST_START_OFF: assert property (start[i] |=> !on[i])
      else $error("Supply stays on after reset start");
    AST_ZERO_DELAY: assert property (start[i] && ctl_q[3:2] == 2'b00
      |=> !on[i] ##1 on[i] && done[i])
      else $error("Zero delay restart mistimed");
    AST_SELF_CLEAR: assert property (start[i] && !wr |=> !ctl_q[i])
      else $error("Reset bit did not clear on start");
    AST_TRIP: assert property (trip[i] == $past(temp[i] > tlvl[i]))
      else $error("Trip flag does not follow measurement");
    AST_NO_DEBOUNCE: assert property (nodeb[i] && raw[i] |=> warn[i])
      else $error("Undebounced warning late");
    AST_DEBOUNCE_HOLD: assert property (!nodeb[i] && $rose(raw[i]) && !warn[i]
      && DEBOUNCE_CYC > 2 |=> !warn[i])
      else $error("Debounced warning rose at once");
    AST_WARN_PG: assert property (trig[i] && warn[i] |=> !pg[i])
      else $error("Warning did not pull power-good");
    AST_UV_PG: assert property (uv[i] || checksum_flag || ss[i] |=> !pg[i])
      else $error("Fault source did not pull power-good");
    COV_RESTART: cover property (start[i] ##[1:8] done[i]);
    COV_WARN: cover property ($rose(warn[i]) && trig[i]);
  end

  AST_CS_DEFAULT: assert property ($past(rst) |-> cs_q == 2'b00)
    else $error("Refresh rate not fastest after reset");
  AST_CS_PERIOD: assert property (cs_cnt_q == cs_lim - 22'h1 |=> cs_pulse_q)
    else $error("Refresh pulse missing at interval end");
  COV_IRQ: cover property ($rose(irq));

  assign supply_on_a = on[0];
  assign supply_on_b = on[1];
  assign overtemp_trip_zone_one = trip[0];
  assign overtemp_trip_zone_two = trip[1];
  assign overtemp_warning_one = warn[0];
  assign overtemp_warning_two = warn[1];
  assign power_ok_channel_a = pg[0];
  assign power_ok_channel_b = pg[1];
endmodule

// ==== core/scfg_defs.svh ====
// Offsets, field positions, reset values and timing figures of the config block
`ifndef SCFG_DEFS_SVH
`define SCFG_DEFS_SVH
`define SCFG_ADDR_RST_CTL 16'hFE88
`define SCFG_ADDR_CS_RATE 16'hFE89
`define SCFG_ADDR_OTW 16'hFE8A
`define SCFG_ADDR_IRQ_STAT 16'hFE8B
`define SCFG_ADDR_IRQ_MASK 16'hFE8C
`define SCFG_ADDR_LS_EN 16'hFE8D
`define SCFG_RST_CTL_RESET 4'h0
`define SCFG_CS_RATE_RESET 2'h0
`define SCFG_OTW_RESET 8'h00
`define SCFG_IRQ_MASK_RESET 4'h0
`define SCFG_LS_EN_RESET 2'h0
`define SCFG_DLY_LSB 2
`define SCFG_OTW_THR1_LSB 0
`define SCFG_OTW_TRIG1 2
`define SCFG_OTW_NODEB1 3
`define SCFG_OTW_THR2_LSB 4
`define SCFG_OTW_TRIG2 6
`define SCFG_OTW_NODEB2 7
`define SCFG_IRQ_DONE_LSB 0
`define SCFG_IRQ_WARN_LSB 2
`define SCFG_CLK_MHZ 10
`define SCFG_RESTART_500_US 500000
`define SCFG_RESTART_1S_US 1000000
`define SCFG_RESTART_2S_US 2000000
`define SCFG_DEBOUNCE_US 100000
`define SCFG_CS_RATE0_US 10500
`define SCFG_CS_RATE1_US 52400
`define SCFG_CS_RATE2_US 104900
`define SCFG_CS_RATE3_US 209700
`define SCFG_US_TO_CYC(us) ((us) * `SCFG_CLK_MHZ)
`endif

// ==== core/scfg_pkg.sv ====
// Types shared by the supply config block
package scfg_pkg;
  typedef logic [7:0] scfg_byte_t;
  typedef logic [15:0] scfg_addr_t;
  typedef logic [1:0] scfg_pair_t;
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_OFF = 2'b01,
    SEQ_RESTART = 2'b10
  } scfg_seq_t;
endpackage

// ==== tb/scfg_top_tb.sv ====
// Self-checking bench of the supply config block
`timescale 1ns/1ps
`include "scfg_defs.svh"
module scfg_top_tb;
  import scfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  scfg_addr_t addr = 16'h0000;
  scfg_byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  scfg_byte_t rdata;
  scfg_byte_t t1 = 8'h00, t2 = 8'h00, p1 = 8'h64, p2 = 8'h64;
  logic uv_a = 1'b0, uv_b = 1'b0, ss_a = 1'b0, ss_b = 1'b0, crc = 1'b0, ls = 1'b0;
  logic on_a, on_b, trip1, trip2, warn1, warn2, pg_a, pg_b, smp, irq;
  int err_count = 0;
  int cmp_count = 0;
  localparam int unsigned DLY_500_CYC = 5;
  localparam int unsigned DLY_1S_CYC = 10;
  localparam int unsigned DLY_2S_CYC = 20;
  localparam int unsigned DEB_CYC = 8;
  localparam int unsigned RATE0_CYC = 20;
  localparam int unsigned RATE1_CYC = 40;
  localparam int unsigned RATE2_CYC = 60;
  localparam int unsigned RATE3_CYC = 80;
  always #50 clk = ~clk;
  scfg_top #(.RESTART_500_CYC(DLY_500_CYC), .RESTART_1S_CYC(DLY_1S_CYC),
    .RESTART_2S_CYC(DLY_2S_CYC), .DEBOUNCE_CYC(DEB_CYC), .CS_RATE0_CYC(RATE0_CYC),
    .CS_RATE1_CYC(RATE1_CYC), .CS_RATE2_CYC(RATE2_CYC),
    .CS_RATE3_CYC(RATE3_CYC)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .temp_zone_one(t1), .temp_zone_two(t2),
    .trip_level_one(p1), .trip_level_two(p2), .undervoltage_flag_a(uv_a),
    .undervoltage_flag_b(uv_b), .soft_start_filter_flag_a(ss_a),
    .soft_start_filter_flag_b(ss_b), .checksum_flag(crc), .line_sense_flag(ls),
    .supply_on_a(on_a), .supply_on_b(on_b), .overtemp_trip_zone_one(trip1),
    .overtemp_trip_zone_two(trip2), .overtemp_warning_one(warn1),
    .overtemp_warning_two(warn2), .power_ok_channel_a(pg_a), .power_ok_channel_b(pg_b),
    .current_sense_sample(smp), .irq(irq));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr_reg(input scfg_addr_t a, input scfg_byte_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input scfg_addr_t a, input scfg_byte_t exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task gap(input logic [7:0] exp);
    int n;
    n = 0;
    while (smp !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (smp !== 1'b1 && n < 200);
    chk(8'(n), exp);
  endtask
  task test_reset_values;
    chk(irq, 1'b0);
    rd_chk(`SCFG_ADDR_CS_RATE, 8'h00);
    rd_chk(`SCFG_ADDR_OTW, 8'h00);
    rd_chk(`SCFG_ADDR_RST_CTL, 8'h00);
    rd_chk(`SCFG_ADDR_IRQ_MASK, 8'h00);
    rd_chk(`SCFG_ADDR_LS_EN, 8'h00);
    wr_reg(16'hFE90, 8'hFF);
    rd_chk(16'hFE90, 8'h00);
    rd_chk(`SCFG_ADDR_CS_RATE, 8'h00);
    gap(8'h14);
    $display("reset values done");
  endtask
  task test_rate;
    logic [7:0] exp[4];
    exp = '{8'h14, 8'h28, 8'h3C, 8'h50};
    for (int r = 3; r >= 0; r--)
    begin
      wr_reg(`SCFG_ADDR_CS_RATE, 8'(r));
      rd_chk(`SCFG_ADDR_CS_RATE, 8'(r));
      gap(exp[r]);
      gap(exp[r]);
    end
    $display("refresh rate done");
  endtask
  task run_seq(input int ch, input int d, input logic [7:0] exp);
    int n;
    int w;
    n = 0;
    w = 0;
    wr_reg(`SCFG_ADDR_RST_CTL, 8'((d << 2) | (1 << ch)));
    #1;
    while (((ch ? on_b : on_a) === 1'b1) && w < 6)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    while (((ch ? on_b : on_a) === 1'b0) && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), exp);
    chk(ch ? pg_b : pg_a, 1'b0);
    rd_chk(`SCFG_ADDR_RST_CTL, 8'(d << 2));
  endtask
  task test_sw_reset;
    logic [7:0] exp[4];
    exp = '{8'h01, 8'h06, 8'h0B, 8'h15};
    wr_reg(`SCFG_ADDR_IRQ_MASK, 8'h01);
    for (int d = 0; d < 4; d++)
    begin
      run_seq(0, d, exp[d]);
      chk(on_b, 1'b1);
      chk(irq, 1'b1);
      rd_chk(`SCFG_ADDR_IRQ_STAT, 8'h01);
      cyc(2);
      chk(irq, 1'b0);
    end
    run_seq(1, 1, exp[1]);
    chk(irq, 1'b0);
    rd_chk(`SCFG_ADDR_IRQ_STAT, 8'h02);
    $display("software reset done");
  endtask
  task set_temp(input scfg_byte_t v);
    @(posedge clk);
    t1 <= v;
    t2 <= v;
  endtask
  task test_warn;
    wr_reg(`SCFG_ADDR_IRQ_MASK, 8'h0C);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(`SCFG_ADDR_OTW, {1'b1, 1'b0, 2'(k), 1'b1, 1'b1, 2'(k)});
      set_temp(8'(101 + k));
      cyc(4);
      chk({trip1, trip2}, 2'b11);
      chk({warn1, warn2}, 2'b00);
      set_temp(8'(102 + k));
      cyc(2);
      chk({warn1, warn2}, 2'b11);
      chk({pg_a, pg_b}, 2'b01);
      set_temp(8'h00);
      cyc(3);
    end
    wr_reg(`SCFG_ADDR_OTW, 8'h40);
    set_temp(8'h66);
    cyc(4);
    chk({warn1, warn2}, 2'b00);
    cyc(8);
    chk({warn1, warn2}, 2'b11);
    chk({pg_a, pg_b}, 2'b10);
    set_temp(8'h00);
    cyc(14);
    chk(irq, 1'b1);
    rd_chk(`SCFG_ADDR_IRQ_STAT, 8'h0C);
    $display("warning done");
  endtask
  task test_pg;
    @(posedge clk);
    uv_a <= 1'b1;
    cyc(3);
    chk({pg_a, pg_b}, 2'b01);
    @(posedge clk);
    uv_a <= 1'b0;
    ls <= 1'b1;
    cyc(3);
    chk({pg_a, pg_b}, 2'b11);
    wr_reg(`SCFG_ADDR_LS_EN, 8'h02);
    cyc(3);
    chk({pg_a, pg_b}, 2'b10);
    rd_chk(`SCFG_ADDR_LS_EN, 8'h02);
    @(posedge clk);
    ls <= 1'b0;
    crc <= 1'b1;
    cyc(3);
    chk({pg_a, pg_b}, 2'b00);
    @(posedge clk);
    crc <= 1'b0;
    ss_b <= 1'b1;
    uv_b <= 1'b1;
    cyc(3);
    chk({pg_a, pg_b}, 2'b10);
    @(posedge clk);
    ss_a <= 1'b1;
    ss_b <= 1'b0;
    uv_b <= 1'b0;
    cyc(3);
    chk({pg_a, pg_b}, 2'b01);
    $display("power good done");
  endtask
  task test_trip;
    chk({trip1, trip2}, 2'b00);
    @(posedge clk);
    ss_a <= 1'b0;
    t1 <= 8'h60;
    t2 <= 8'h60;
    p1 <= 8'h50;
    p2 <= 8'h70;
    cyc(2);
    chk({trip1, trip2}, 2'b10);
    @(posedge clk);
    p1 <= 8'h60;
    p2 <= 8'h5F;
    cyc(2);
    chk({trip1, trip2}, 2'b01);
    $display("trip level done");
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    test_reset_values();
    test_rate();
    test_sw_reset();
    test_warn();
    test_pg();
    test_trip();
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
